// ### inc/psdt_pkg.sv
package psdt_pkg;
	// Clock rate and time unit per variant
	localparam int unsigned CLK_PERIOD_PS  = 50000;
	localparam int unsigned UNIT_BASE_PS   = 2000000;
	localparam int unsigned UNIT_FAST_PS   = 800000;
	localparam int unsigned UNIT_PREM_PS   = 900000;
	// Cycles per unit, rounded down, at least one
	localparam int unsigned UNIT_BASE_CYC  = (UNIT_BASE_PS / CLK_PERIOD_PS) > 0 ?
		(UNIT_BASE_PS / CLK_PERIOD_PS) : 1;
	localparam int unsigned UNIT_FAST_CYC  = (UNIT_FAST_PS / CLK_PERIOD_PS) > 0 ?
		(UNIT_FAST_PS / CLK_PERIOD_PS) : 1;
	localparam int unsigned UNIT_PREM_CYC  = (UNIT_PREM_PS / CLK_PERIOD_PS) > 0 ?
		(UNIT_PREM_PS / CLK_PERIOD_PS) : 1;
	localparam int unsigned PRE_W          = 6;
	localparam int unsigned CNT_W          = 16;
	localparam int unsigned PIN_CNT        = 16;
	localparam int unsigned SEL_W          = 4;
	localparam logic [CNT_W-1:0] CNT_MAX   = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
	localparam logic [CNT_W-1:0] OVF_RES   = 16'h0000;
	localparam logic [PRE_W-1:0] PRE_ZERO  = 6'h00;
	localparam logic [PRE_W-1:0] PRE_ONE   = 6'h01;
	// Variant select codes
	localparam logic [1:0] VAR_BASE = 2'h0;
	localparam logic [1:0] VAR_ENH  = 2'h1;
	localparam logic [1:0] VAR_FAST = 2'h2;
	localparam logic [1:0] VAR_PREM = 2'h3;
	typedef enum logic [1:0] {
		PSDT_IDLE  = 2'b00,
		PSDT_MEAS  = 2'b01,
		PSDT_DONE  = 2'b10
	} psdt_state_e;
endpackage

// ### rtl/psdt_unit_tick.sv
`timescale 1ns/100ps
// Divides the clock into one-cycle ticks of one time unit
module psdt_unit_tick (
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             ce_i,
	input  wire logic             run_i,
	input  wire logic [1:0]       variant_i,
	output logic                  tick_o
);
	logic [psdt_pkg::PRE_W-1:0] pre_q;
	logic [psdt_pkg::PRE_W-1:0] pre_d;
	logic [psdt_pkg::PRE_W-1:0] last_w;
	// Terminal count per variant
	assign last_w = (variant_i == psdt_pkg::VAR_FAST) ?
			psdt_pkg::PRE_W'(psdt_pkg::UNIT_FAST_CYC - 1) :
		(variant_i == psdt_pkg::VAR_PREM) ?
			psdt_pkg::PRE_W'(psdt_pkg::UNIT_PREM_CYC - 1) :
			psdt_pkg::PRE_W'(psdt_pkg::UNIT_BASE_CYC - 1);
	assign tick_o = run_i && (pre_q == last_w);
	assign pre_d  = (!run_i || tick_o) ? psdt_pkg::PRE_ZERO : pre_q + psdt_pkg::PRE_ONE;
	// Prescaler register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_q <= psdt_pkg::PRE_ZERO;
		end else if (ce_i) begin
			pre_q <= pre_d;
		end
	end
endmodule // psdt_unit_tick

// ### rtl/psdt_level_duration_measure.sv
`timescale 1ns/100ps
// Functional notes
// [RULE_01] A four-bit selector picks one of sixteen pins and the start releases its driver.
// [RULE_02] A one-bit target level is watched and the first mismatching sample ends the count.
// [RULE_03] The counter advances once per unit: 2 us base/enhanced, 0.8 us fast, 0.9 us premium.
// [RULE_04] Counting stops at once when the mismatch is seen, with no further units added.
// [RULE_05] A pin already off target at start gives a result of 1.
// [RULE_06] Holding the level past 65535 units ends the measurement with result 0.
// [RULE_07] Software must precharge the external network so the pin reads the target first.
// [RULE_08] Software should drive the pin high about 1 ms then measure with target 1.
// [RULE_09] The result sits in a 16-bit register with a one-cycle done pulse for every end.
module psdt_level_duration_measure (
	input  wire logic                       clk_i,
	input  wire logic                       reset_n_i,
	input  wire logic                       ce_i,
	input  wire logic [1:0]                 variant_i,
	input  wire logic                       start_i,
	input  wire logic [psdt_pkg::SEL_W-1:0] pin_sel_i,
	input  wire logic                       target_i,
	input  wire logic [psdt_pkg::PIN_CNT-1:0] pin_in_i,
	input  wire logic [psdt_pkg::PIN_CNT-1:0] pin_out_i,
	input  wire logic [psdt_pkg::PIN_CNT-1:0] pin_oe_i,
	output logic [psdt_pkg::PIN_CNT-1:0]    pin_out_o,
	output logic [psdt_pkg::PIN_CNT-1:0]    pin_oe_o,
	output logic                            busy_o,
	output logic                            done_o,
	output logic                            overflow_o,
	output logic [psdt_pkg::CNT_W-1:0]      result_o
);
	// Captured command, live count and finished result
	psdt_pkg::psdt_state_e        state_q;
	psdt_pkg::psdt_state_e        state_d;
	logic [psdt_pkg::SEL_W-1:0]   sel_q;
	logic [psdt_pkg::SEL_W-1:0]   sel_d;
	logic                         tgt_q;
	logic                         tgt_d;
	logic [1:0]                   var_q;
	logic [1:0]                   var_d;
	logic [psdt_pkg::CNT_W-1:0]   cnt_q;
	logic [psdt_pkg::CNT_W-1:0]   cnt_d;
	logic [psdt_pkg::CNT_W-1:0]   cnt_inc_w;
	logic [psdt_pkg::CNT_W-1:0]   res_q;
	logic [psdt_pkg::CNT_W-1:0]   res_d;
	logic                         ovf_q;
	logic                         ovf_d;
	logic [psdt_pkg::PIN_CNT-1:0] sel_hot_w;
	logic [psdt_pkg::PIN_CNT-1:0] rel_mask_w;
	logic                         idle_w;
	logic                         run_w;
	logic                         end_w;
	logic                         tick_w;
	logic                         level_w;
	logic                         mismatch_w;
	logic                         limit_w;
	logic                         take_w;
	logic                         finish_w;

	// One-hot decode of a pin selector
	function automatic logic [psdt_pkg::PIN_CNT-1:0] psdt_onehot(
		input logic [psdt_pkg::SEL_W-1:0] s);
		psdt_onehot = {{(psdt_pkg::PIN_CNT-1){1'b0}}, 1'b1} << s;
	endfunction

	// Phase compare, shared by the three phase decodes below
	function automatic logic psdt_in_state(
		input psdt_pkg::psdt_state_e cur,
		input psdt_pkg::psdt_state_e want);
		psdt_in_state = (cur == want);
	endfunction

	// Phase decode
	assign idle_w = psdt_in_state(state_q, psdt_pkg::PSDT_IDLE);
	assign run_w  = psdt_in_state(state_q, psdt_pkg::PSDT_MEAS);
	assign end_w  = psdt_in_state(state_q, psdt_pkg::PSDT_DONE);

	// Selector expanded once for the per-pin logic
	assign sel_hot_w = psdt_onehot(sel_q);

	// Per-pin release: only the captured pin, only while counting, so a
	// pin that other logic drives comes back the cycle after the count ends
	for (genvar p = 0; p < psdt_pkg::PIN_CNT; p++) begin : g_pin
		logic rel_w;
		assign rel_w         = run_w && sel_hot_w[p];
		assign rel_mask_w[p] = rel_w;
		assign pin_out_o[p]  = pin_out_i[p] && !rel_w;
		assign pin_oe_o[p]   = pin_oe_i[p] && !rel_w; // [RULE_01]
	end

	// Command capture; held through the run so a changing selector,
	// level or variant on the inputs cannot bend a measurement
	assign sel_d = take_w ? pin_sel_i : sel_q;
	assign tgt_d = take_w ? target_i : tgt_q;
	assign var_d = take_w ? variant_i : var_q;

	// Sampling and termination decode; the pin is looked at only on a
	// unit tick, so a short glitch between ticks is not seen
	assign take_w     = idle_w && start_i;
	assign level_w    = pin_in_i[sel_q];
	assign mismatch_w = tick_w && (level_w != tgt_q); // [RULE_02] [RULE_05]
	assign limit_w    = tick_w && (cnt_q == psdt_pkg::CNT_MAX); // [RULE_06]
	assign finish_w   = mismatch_w || limit_w;
	assign cnt_inc_w  = cnt_q + psdt_pkg::CNT_ONE;

	// Unit prescaler; runs only in the counting phase, so the first unit
	// is a full one and the pin is first looked at one unit after start
	psdt_unit_tick u_tick (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.run_i     (run_w),
		.variant_i (var_q),
		.tick_o    (tick_w)
	); // [RULE_03]

	// Phase sequencing; a start seen in the done phase is dropped, and
	// the caller must present it again once the block is idle
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			psdt_pkg::PSDT_IDLE: begin
				if (take_w) begin
					state_d = psdt_pkg::PSDT_MEAS;
				end
			end
			psdt_pkg::PSDT_MEAS: begin
				if (finish_w) begin
					state_d = psdt_pkg::PSDT_DONE;
				end
			end
			psdt_pkg::PSDT_DONE: begin
				state_d = psdt_pkg::PSDT_IDLE;
			end
			default: begin
				state_d = psdt_pkg::PSDT_IDLE;
			end
		endcase
	end

	// Count and result update; the mismatch is checked before the limit
	// so the detecting unit is part of the reported count, which wraps to 0 when the mismatch is on unit 65536
	always_comb begin
		cnt_d = cnt_q;
		res_d = res_q;
		ovf_d = ovf_q;
		if (take_w) begin
			cnt_d = psdt_pkg::CNT_ZERO;
		end else if (mismatch_w) begin
			res_d = cnt_inc_w; // [RULE_04] [RULE_05]
			ovf_d = 1'b0;
		end else if (limit_w) begin
			res_d = psdt_pkg::OVF_RES; // [RULE_06]
			ovf_d = 1'b1;
		end else if (tick_w) begin
			cnt_d = cnt_inc_w; // [RULE_03]
		end
	end

	// Phase register; a low enable freezes it
	// together with every other register below
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= psdt_pkg::PSDT_IDLE;
		end else if (ce_i) begin
			state_q <= state_d;
		end
	end

	// Command registers; only loaded on an accepted start
	// so a start refused while busy leaves them alone
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sel_q <= '0;
			tgt_q <= 1'b0;
			var_q <= psdt_pkg::VAR_BASE;
		end else if (ce_i) begin
			sel_q <= sel_d;
			tgt_q <= tgt_d;
			var_q <= var_d;
		end
	end

	// Unit counter; cleared at start, never touched after the end
	// so the last count stays visible for debugging
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_q <= psdt_pkg::CNT_ZERO;
		end else if (ce_i) begin
			cnt_q <= cnt_d;
		end
	end

	// Result register; written only when a measurement ends
	// and held until the next one ends
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			res_q <= psdt_pkg::CNT_ZERO;
		end else if (ce_i) begin
			res_q <= res_d; // [RULE_09]
		end
	end

	// Overflow flag; set and cleared only at the end of a run
	// so it always describes the result beside it
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ovf_q <= 1'b0;
		end else if (ce_i) begin
			ovf_q <= ovf_d;
		end
	end

	// Status outputs; the done pulse is masked by the enable so a
	// frozen block does not stretch it over several clocks
	assign busy_o     = !idle_w;
	assign done_o     = end_w && ce_i; // [RULE_09]
	assign overflow_o = ovf_q;
	assign result_o   = res_q;
endmodule // psdt_level_duration_measure

// ### dv/psdt_monitor.sv
`timescale 1ns/100ps
module psdt_monitor (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        ce_i,
	input wire logic        start_i,
	input wire logic [3:0]  pin_sel_i,
	input wire logic [15:0] pin_oe_o,
	input wire logic        busy_o,
	input wire logic        done_o,
	input wire logic        overflow_o,
	input wire logic [15:0] result_o
);
	// Quiet while frozen or in reset
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i || !ce_i);
	sequence s_take;
		!busy_o && start_i;
	endsequence
	sequence s_end;
		busy_o ##1 !busy_o && !done_o;
	endsequence
	AST_BUSY: assert property (s_take |=> busy_o)
		else $error("busy late");
	AST_FREE: assert property (s_take |=> !pin_oe_o[$past(pin_sel_i)])
		else $error("pin driven");
	AST_UNIT: assert property (s_take |=> !done_o [*8])
		else $error("done early");
	AST_PULSE: assert property (done_o |-> s_end)
		else $error("bad done");
	AST_HOLD: assert property ($changed(result_o) |-> done_o)
		else $error("result moved");
	AST_OVF: assert property (done_o && overflow_o |-> result_o == 16'h0000)
		else $error("ovf result");
	AST_STOP: assert property (done_o && !overflow_o |-> result_o != 16'h0000)
		else $error("zero result");
endmodule // psdt_monitor

bind psdt_level_duration_measure psdt_monitor mon_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.ce_i(ce_i), .start_i(start_i), .pin_sel_i(pin_sel_i), .pin_oe_o(pin_oe_o),
	.busy_o(busy_o), .done_o(done_o), .overflow_o(overflow_o), .result_o(result_o));

// ### dv/psdt_rc_model.sv
`timescale 1ns/100ps
module psdt_rc_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] pin_out_i,
	input  wire logic [15:0] pin_oe_i,
	input  wire logic        target_i,
	input  wire logic [15:0] hold_i,
	output logic      [15:0] pin_in_o
);
	int cnt_q = 0;
	// Cycles since a pin was released
	always_ff @(posedge clk_i) cnt_q <= &pin_oe_i ? 0 : cnt_q + 1;
	// Driven pins read back; released ones keep the level, then cross
	assign pin_in_o = pin_oe_i & pin_out_i |
		~pin_oe_i & {16{target_i ^ (cnt_q >= hold_i)}};
endmodule // psdt_rc_model

// ### dv/tb_pin_state_duration_timer.sv
`timescale 1ns/100ps
module tb_pin_state_duration_timer;
	logic        clk_i = 0, reset_n_i = 0, start_i = 0, target_i = 0;
	logic [1:0]  variant_i = 0;
	logic [3:0]  pin_sel_i = 0;
	logic [15:0] hold = 0;
	logic [15:0] pin_in_i, pin_out_o, pin_oe_o, result_o;
	logic        busy_o, done_o, overflow_o;
	int          err_count = 0;
	int          n_compared = 0;
	// Pins stay precharged to the watched level while driven
	psdt_level_duration_measure dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
		.variant_i(variant_i), .start_i(start_i), .pin_sel_i(pin_sel_i), .target_i(target_i),
		.pin_in_i(pin_in_i), .pin_out_i({16{target_i}}), .pin_oe_i(16'hFFFF),
		.pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .busy_o(busy_o), .done_o(done_o),
		.overflow_o(overflow_o), .result_o(result_o));
	psdt_rc_model rc_u (.clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
		.target_i(target_i), .hold_i(hold), .pin_in_o(pin_in_i));
	initial forever #25 clk_i = ~clk_i;
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One measurement; the pin holds for m units and a half
	task automatic meas(logic [1:0] v, logic [3:0] s, logic t, int m);
		int n;
		int i;
		n = v == 2'h2 ? psdt_pkg::UNIT_FAST_CYC : v == 2'h3 ? psdt_pkg::UNIT_PREM_CYC :
			psdt_pkg::UNIT_BASE_CYC;
		variant_i = v;
		pin_sel_i = s;
		target_i = t;
		hold = 16'(m * n + n / 2);
		start_i = 1;
		@(posedge clk_i) #1 start_i = 0;
		chk("oe", 16'h0, 16'(pin_oe_o[s]));
		i = 0;
		while (done_o !== 1'b1 && i < 5000)
			@(posedge clk_i) #1 i++;
		chk("cycles", 16'((m + 1) * n), 16'(i));
		chk("result", 16'(m + 1), result_o);
		chk("ovf", 16'h0, 16'(overflow_o));
		@(posedge clk_i) #1 chk("busy", 16'h0, 16'(busy_o));
	endtask
	task automatic t_pins;
		meas(2'h0, 4'h0, 1'b1, 2);
		meas(2'h0, 4'hF, 1'b0, 2);
	endtask
	task automatic t_units;
		for (int v = 0; v < 4; v++)
			meas(2'(v), 4'h5, 1'b1, 3);
	endtask
	task automatic t_quick;
		meas(2'h2, 4'h9, 1'b1, 0);
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		#1 reset_n_i = 1;
		t_pins();
		t_units();
		t_quick();
		end_of_test();
	end
	// Watchdog
	initial begin
		#2000000;
		err_count++;
		end_of_test();
	end
endmodule // tb_pin_state_duration_timer
